// [rcs_pkg.sv]
package rcs_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned PC_W      = 21;
  localparam int unsigned OFF_W     = 11;
  localparam int unsigned INST_W    = 16;
  localparam int unsigned PTR_W     = 5;
  localparam int unsigned STK_DEPTH = 31;

  // ****************************************
  // Reset values and steps
  // ****************************************
  localparam logic [PC_W-1:0]  PC_RST   = 21'h000000;
  localparam logic [PC_W-1:0]  PC_STEP  = 21'h000002;
  localparam logic [PTR_W-1:0] PTR_RST  = 5'h00;
  localparam logic [PTR_W-1:0] PTR_FULL = 5'h1f;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [INST_W-1:0] OPC_PUSH   = 16'h0005;
  localparam logic [INST_W-1:0] OPC_POP    = 16'h0006;
  localparam logic [INST_W-1:0] OPC_RESET  = 16'h00ff;
  localparam logic [INST_W-1:0] OPC_RELATIVE_SUBROUTINE_CALL  = 16'hd800;
  localparam logic [INST_W-1:0] MASK_RELATIVE_SUBROUTINE_CALL = 16'hf800;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    Q_1 = 2'h0,
    Q_2 = 2'h1,
    Q_3 = 2'h3,
    Q_4 = 2'h2
  } rcs_q_e;

  typedef enum logic [0:0] {
    CY_EXEC   = 1'h0,
    CY_REFILL = 1'h1
  } rcs_cyc_e;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_PUSH  = 3'h1,
    OP_POP   = 3'h3,
    OP_RELATIVE_SUBROUTINE_CALL = 3'h2,
    OP_RESET = 3'h6
  } rcs_op_e;

  function automatic rcs_op_e rcs_dec_op(input logic [INST_W-1:0] instr);
    rcs_op_e op;
    op = OP_NONE;
    if ((instr & MASK_RELATIVE_SUBROUTINE_CALL) == OPC_RELATIVE_SUBROUTINE_CALL) begin
      op = OP_RELATIVE_SUBROUTINE_CALL;
    end else if (instr == OPC_PUSH) begin
      op = OP_PUSH;
    end else if (instr == OPC_POP) begin
      op = OP_POP;
    end else if (instr == OPC_RESET) begin
      op = OP_RESET;
    end
    return op;
  endfunction : rcs_dec_op

endpackage : rcs_pkg

// [rcs_stk_if.sv]
`timescale 1ns/1ps
interface rcs_stk_if;
  import rcs_pkg::*;
  logic              push;
  logic              pop;
  logic              clr;
  logic [PC_W-1:0]   wdata;
  logic [PC_W-1:0]   top;
  logic [PTR_W-1:0]  ptr;

  modport ctl (output push, output pop, output clr, output wdata,
               input top, input ptr);
  modport stk (input push, input pop, input clr, input wdata,
               output top, output ptr);
endinterface : rcs_stk_if

// [rcs_ret_stack.sv]
`timescale 1ns/1ps
module rcs_ret_stack
  import rcs_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_b,
  rcs_stk_if.stk     stk
);

  logic [PC_W-1:0]  mem [STK_DEPTH];
  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] nxt_ptr;
  logic             wr_en;

  // ****************************************
  // Pointer
  // ****************************************
  always_comb begin
    nxt_ptr = ptr_ff;
    wr_en   = 1'b0;
    if (stk.clr) begin
      nxt_ptr = PTR_RST;
    end else if (stk.push && ptr_ff != PTR_FULL) begin
      nxt_ptr = ptr_ff + 5'h01;
      wr_en   = 1'b1;
    end else if (stk.pop && ptr_ff != PTR_RST) begin
      nxt_ptr = ptr_ff - 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_ff <= PTR_RST;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (wr_en) begin
      mem[ptr_ff] <= stk.wdata;
    end
  end

  assign stk.top = (ptr_ff == PTR_RST) ? PC_RST : mem[ptr_ff - 5'h01];
  assign stk.ptr = ptr_ff;

endmodule : rcs_ret_stack

// [rcs_core_ops.sv]
`timescale 1ns/1ps
// Function
// RQ1: Relative call pushes its own address plus 2 before the PC changes.
// RQ2: Call operand is a signed word offset, doubled to bytes.
// RQ3: Call target is call address plus 2 plus doubled offset.
// RQ4: Call offsets span -1024 to 1023 words.
// RQ5: Relative call is one word, two cycles; second cycle does nothing.
// RQ6: Software reset returns all master-clear registers to reset values.
// RQ7: Push stores PC plus 2 as new top; PC flow and flags untouched.
// RQ8: Pop discards the top entry; the one below becomes top.
module rcs_core_ops
  import rcs_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  input  wire logic [INST_W-1:0]  i_instr,
  output logic      [PC_W-1:0]    o_pc,
  output logic      [1:0]         o_q_phase,
  output logic                    o_refill_cycle,
  output logic      [PC_W-1:0]    o_stack_top_entry,
  output logic      [PTR_W-1:0]   o_stack_ptr,
  output logic                    o_master_clear_reset
);

  rcs_stk_if stk_if ();

  rcs_q_e            q_ff;
  rcs_q_e            nxt_q;
  rcs_cyc_e          cyc_ff;
  rcs_cyc_e          nxt_cyc;
  rcs_op_e           op_ff;
  rcs_op_e           nxt_op;
  logic [OFF_W-1:0]  off_ff;
  logic [OFF_W-1:0]  nxt_off;
  logic [PC_W-1:0]   pc_ff;
  logic [PC_W-1:0]   nxt_pc;
  logic [PC_W-1:0]   top_ff;
  logic [PC_W-1:0]   nxt_top;
  logic              master_clear_reset_ff;
  logic              nxt_master_clear_reset;
  logic [PC_W-1:0]   ret_addr;
  logic [PC_W-1:0]   disp;

  // ****************************************
  // Return stack
  // ****************************************
  rcs_ret_stack u_stack (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .stk       (stk_if.stk)
  );

  assign ret_addr = pc_ff + PC_STEP;
  // Sign extend and double the word offset
  assign disp     = {{(PC_W-OFF_W-1){off_ff[OFF_W-1]}}, off_ff, 1'b0}; // [RQ2] [RQ4]

  always_comb begin
    stk_if.push  = (q_ff == Q_2) && (op_ff == OP_PUSH || op_ff == OP_RELATIVE_SUBROUTINE_CALL); // [RQ1] [RQ7]
    stk_if.wdata = ret_addr; // [RQ1] [RQ7]
    stk_if.pop   = (q_ff == Q_3) && (op_ff == OP_POP); // [RQ8]
    stk_if.clr   = (q_ff == Q_4) && (op_ff == OP_RESET); // [RQ6]
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_q    = q_ff;
    nxt_cyc  = cyc_ff;
    nxt_op   = op_ff;
    nxt_off  = off_ff;
    nxt_pc   = pc_ff;
    nxt_master_clear_reset = 1'b0;
    nxt_top  = stk_if.top;
    unique case (q_ff)
      Q_1: begin
        nxt_q = Q_2;
        if (cyc_ff == CY_EXEC) begin
          nxt_op  = rcs_dec_op(i_instr);
          nxt_off = i_instr[OFF_W-1:0];
        end else begin
          nxt_op  = OP_NONE; // [RQ5]
        end
      end
      Q_2: begin
        nxt_q = Q_3;
      end
      Q_3: begin
        nxt_q = Q_4;
      end
      Q_4: begin
        nxt_q   = Q_1;
        nxt_cyc = CY_EXEC;
        if (cyc_ff == CY_REFILL) begin
          nxt_pc = pc_ff; // [RQ5]
        end else begin
          unique case (op_ff)
            OP_RELATIVE_SUBROUTINE_CALL: begin
              nxt_pc  = ret_addr + disp; // [RQ3]
              nxt_cyc = CY_REFILL; // [RQ5]
            end
            OP_RESET: begin
              nxt_pc   = PC_RST; // [RQ6]
              nxt_master_clear_reset = 1'b1; // [RQ6]
            end
            default: begin
              nxt_pc = ret_addr; // [RQ7]
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff    <= Q_1;
      cyc_ff  <= CY_EXEC;
      op_ff   <= OP_NONE;
      off_ff  <= '0;
      pc_ff   <= PC_RST;
      top_ff  <= PC_RST;
      master_clear_reset_ff <= 1'b0;
    end else begin
      q_ff    <= nxt_q;
      cyc_ff  <= nxt_cyc;
      op_ff   <= nxt_op;
      off_ff  <= nxt_off;
      pc_ff   <= nxt_pc;
      top_ff  <= nxt_top;
      master_clear_reset_ff <= nxt_master_clear_reset;
    end
  end

  assign o_pc                 = pc_ff;
  assign o_q_phase            = q_ff;
  assign o_refill_cycle       = cyc_ff[0];
  assign o_stack_top_entry    = top_ff;
  assign o_stack_ptr          = stk_if.ptr;
  assign o_master_clear_reset = master_clear_reset_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_relative_subroutine_call_q4;
    (q_ff == Q_4) && (op_ff == OP_RELATIVE_SUBROUTINE_CALL) && (cyc_ff == CY_EXEC);
  endsequence

  sequence s_refill_cycle;
    (cyc_ff == CY_REFILL) [*4];
  endsequence

  property p_relative_subroutine_call_ret;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ((q_ff == Q_2) && (op_ff == OP_RELATIVE_SUBROUTINE_CALL) && (stk_if.ptr != PTR_FULL))
      |-> ##2 (top_ff == $past(pc_ff, 2) + PC_STEP);
  endproperty
  a_relative_subroutine_call_ret: assert property (p_relative_subroutine_call_ret) // [RQ1]
    else $error("Call return address not on stack top");

  property p_relative_subroutine_call_back2;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (s_relative_subroutine_call_q4 and (off_ff == 11'h7ff)) |=> (pc_ff == $past(pc_ff));
  endproperty
  a_relative_subroutine_call_back2: assert property (p_relative_subroutine_call_back2) // [RQ2]
    else $error("Offset of minus one word not signed and doubled");

  property p_relative_subroutine_call_tgt;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_relative_subroutine_call_q4 |=> (pc_ff == $past(pc_ff) + PC_STEP
                               + PC_W'($signed($past(off_ff)) * 2));
  endproperty
  a_relative_subroutine_call_tgt: assert property (p_relative_subroutine_call_tgt) // [RQ3]
    else $error("Call target wrong");

  property p_relative_subroutine_call_reach;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_relative_subroutine_call_q4 |=> ((((pc_ff - $past(pc_ff) - PC_STEP) >> 11) == 21'h0)
                  || (((pc_ff - $past(pc_ff) - PC_STEP) >> 11) == 21'h3ff));
  endproperty
  a_relative_subroutine_call_reach: assert property (p_relative_subroutine_call_reach) // [RQ4]
    else $error("Call displacement out of reach");

  property p_relative_subroutine_call_two;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_relative_subroutine_call_q4 |=> s_refill_cycle ##1 (cyc_ff == CY_EXEC)
                  && (pc_ff == $past(pc_ff, 4));
  endproperty
  a_relative_subroutine_call_two: assert property (p_relative_subroutine_call_two) // [RQ5]
    else $error("Call second cycle not an idle refill");

  property p_soft_rst;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ((q_ff == Q_4) && (op_ff == OP_RESET)) |=>
        (pc_ff == PC_RST) && (stk_if.ptr == PTR_RST) && o_master_clear_reset;
  endproperty
  a_soft_rst: assert property (p_soft_rst) // [RQ6]
    else $error("Software reset did not clear state");

  property p_push;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ((q_ff == Q_2) && (op_ff == OP_PUSH) && (stk_if.ptr != PTR_FULL)) |=>
        (stk_if.ptr == $past(stk_if.ptr) + 5'h01)
        ##2 (pc_ff == $past(pc_ff, 3) + PC_STEP);
  endproperty
  a_push: assert property (p_push) // [RQ7]
    else $error("Push did not deepen stack or broke PC flow");

  property p_pop;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ((q_ff == Q_3) && (op_ff == OP_POP) && (stk_if.ptr != PTR_RST)) |=>
        (stk_if.ptr == $past(stk_if.ptr) - 5'h01);
  endproperty
  a_pop: assert property (p_pop) // [RQ8]
    else $error("Pop did not discard top entry");

  property p_push_top;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      ((q_ff == Q_2) && (op_ff == OP_PUSH) && (stk_if.ptr != PTR_FULL))
      |-> ##2 (top_ff == $past(pc_ff, 2) + PC_STEP);
  endproperty
  a_push_top: assert property (p_push_top) // [RQ7]
    else $error("Push did not place return address on top");

  property p_refill_idle;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (cyc_ff == CY_REFILL) |-> !stk_if.push && !stk_if.pop && !stk_if.clr;
  endproperty
  a_refill_idle: assert property (p_refill_idle) // [RQ5]
    else $error("Stack touched during call refill cycle");

endmodule : rcs_core_ops

// [rcs_core_ops_tb.sv]
`timescale 1ns/1ps
module rcs_core_ops_tb
  import rcs_pkg::*;
;
  localparam int TMO = 3000;

  logic              clk;
  logic              rst_b;
  logic [INST_W-1:0] instr;
  logic [PC_W-1:0]   pc;
  logic [1:0]        q_ph;
  logic              refill;
  logic [PC_W-1:0]   top;
  logic [PTR_W-1:0]  ptr;
  logic              master_clear_reset;
  int                err_count;
  int                cmp_count;
  int                cyc;

  rcs_core_ops u_rcs_core_ops (
    .i_ref_clk            (clk),
    .i_rst_b              (rst_b),
    .i_instr              (instr),
    .o_pc                 (pc),
    .o_q_phase            (q_ph),
    .o_refill_cycle       (refill),
    .o_stack_top_entry    (top),
    .o_stack_ptr          (ptr),
    .o_master_clear_reset (master_clear_reset)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == TMO) begin
      err_count++;
      print_verdict();
    end
  end

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  // Returns at the taking edge, with the pc of the taken word
  task automatic issue(input logic [INST_W-1:0] op,
                       output logic [PC_W-1:0] p);
    int n;
    n = 0;
    @(posedge clk);
    instr <= op;
    do begin
      @(negedge clk);
      n++;
    end while (!(q_ph === Q_1 && refill === 1'b0) && n < 20);
    p = pc;
    @(posedge clk);
    instr <= 16'h0000;
  endtask : issue

  task automatic wait_ans;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : wait_ans

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_plain;
    logic [PC_W-1:0] p;
    issue(16'h1234, p);
    wait_ans();
    check("plain pc", pc, p + PC_STEP);
    issue(OPC_POP, p);
    wait_ans();
    check("pop empty ptr", ptr, 0);
  endtask : t_plain

  task automatic t_push_pop;
    logic [PC_W-1:0]  p0;
    logic [PC_W-1:0]  p1;
    logic [PTR_W-1:0] d;
    d = ptr;
    issue(OPC_PUSH, p0);
    wait_ans();
    check("push pc", pc, p0 + PC_STEP);
    check("push top", top, p0 + PC_STEP);
    check("push ptr", ptr, d + 1);
    issue(OPC_PUSH, p1);
    wait_ans();
    check("push2 top", top, p1 + PC_STEP);
    issue(OPC_POP, p1);
    wait_ans();
    check("pop top", top, p0 + PC_STEP);
    check("pop ptr", ptr, d + 1);
    check("pop pc", pc, p1 + PC_STEP);
  endtask : t_push_pop

  task automatic t_call(input logic [OFF_W-1:0] off);
    logic [PC_W-1:0]  p;
    logic [PC_W-1:0]  tgt;
    logic [PTR_W-1:0] d;
    d = ptr;
    issue(OPC_RELATIVE_SUBROUTINE_CALL | {5'h00, off}, p);
    tgt = p + PC_STEP + {{(PC_W-OFF_W-1){off[OFF_W-1]}}, off, 1'b0};
    repeat (2) @(posedge clk);
    // Push offered in the refill cycle must be refused
    instr <= OPC_PUSH;
    @(negedge clk);
    check("call early top", top, p + PC_STEP);
    check("call early pc", pc, p);
    @(negedge clk);
    check("call pc", pc, tgt);
    check("call ptr", ptr, d + 1);
    check("refill on", refill, 1);
    repeat (3) begin
      @(negedge clk);
      check("refill held", refill, 1);
      check("refill pc", pc, tgt);
      check("refill ptr", ptr, d + 1);
    end
    @(posedge clk);
    instr <= 16'h0000;
    @(negedge clk);
    check("refill off", refill, 0);
    check("after ptr", ptr, d + 1);
    check("after pc", pc, tgt);
  endtask : t_call

  task automatic t_full;
    logic [PC_W-1:0] p;
    logic [PC_W-1:0] t;
    for (int i = 0; i < 31 && ptr !== PTR_FULL; i++) begin
      issue(OPC_PUSH, p);
      wait_ans();
    end
    t = top;
    issue(OPC_PUSH, p);
    wait_ans();
    check("full ptr", ptr, PTR_FULL);
    check("full top", top, t);
  endtask : t_full

  task automatic t_reset;
    logic [PC_W-1:0] p;
    issue(OPC_RESET, p);
    wait_ans();
    check("sw rst pc", pc, PC_RST);
    check("sw rst ptr", ptr, PTR_RST);
    check("sw rst pulse", master_clear_reset, 1);
    check("sw rst q", q_ph, Q_1);
    @(negedge clk);
    check("sw rst end", master_clear_reset, 0);
    check("sw rst top", top, PC_RST);
  endtask : t_reset

  initial begin
    rst_b = 1'b0;
    instr = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    check("hw rst pc", pc, PC_RST);
    check("hw rst ptr", ptr, PTR_RST);
    check("hw rst master_clear_reset", master_clear_reset, 0);
    t_plain();
    t_push_pop();
    t_call(11'h000);
    t_call(11'h001);
    t_call(11'h7ff);
    t_call(11'h3ff);
    t_call(11'h400);
    t_full();
    t_reset();
    t_push_pop();
    print_verdict();
  end

endmodule : rcs_core_ops_tb
